// ===== hw/dio_port_block.sv
// digital i/o port block: port bytes, single-pin bytes, port-byte output enable and routing
`timescale 1ns/10ps
`default_nettype none
module dio_port_block
  import dio_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [15:0] xram_addr,
  input wire logic xram_wr,
  input wire logic [7:0] xram_wdata,
  output logic [7:0] xram_rdata,
  input wire logic [24:0] pin_in,
  output logic [24:0] pin_out,
  output logic [24:0] pin_oe,
  input wire logic push_button_input,
  input wire logic [3:0] ce_pulse,
  output logic pulse_irq,
  output logic counter0_clock_input,
  output logic counter1_clock_input,
  output logic high_priority_ext_irq,
  output logic low_priority_ext_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address tables and helpers

  // sfr address of a port byte
  function automatic logic [7:0] bank_addr(input int b);
    case (b)
      0: bank_addr = DIO_SFR_BANK_A;
      1: bank_addr = DIO_SFR_BANK_B;
      2: bank_addr = DIO_SFR_BANK_C;
      default: bank_addr = DIO_SFR_BANK_D;
    endcase
  endfunction : bank_addr

  // writable bits of a port byte; the last byte has only three pins
  function automatic logic [7:0] bank_mask(input int b);
    bank_mask = (b == 3) ? DIO_BANK_D_MASK : 8'hff;
  endfunction : bank_mask

  // i/o ram address of a single-pin byte: pins 19..25, 28, 29, 55
  function automatic logic [15:0] single_addr(input int i);
    if (i < 7)
      single_addr = DIO_XRAM_SINGLE_BASE + 16'(i + 3);
    else if (i < 9)
      single_addr = DIO_XRAM_SINGLE_BASE + 16'(i + 5);
    else
      single_addr = DIO_XRAM_PIN55;
  endfunction : single_addr

  ////////////////////////////////////////////////////////////////////////////
  // state

  dio_state_t st;
  dio_state_t next_st;

  dio_route_if rt ();

  // routed levels: pins 2..11 then the push button
  assign rt.level = {st.btn_sync, st.pin_sync[11:2]};
  assign rt.sel = st.rsel;

  dio_resource_router u_router (
    .rt (rt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    next_st = st;

    // two-stage synchronisers on every pad and the push button
    next_st.meta = pin_in;
    next_st.pin_sync = st.meta;
    next_st.btn_meta = push_button_input;
    next_st.btn_sync = st.btn_meta; // input only, no drive control

    // port byte writes over the sfr port
    for (int b = 0; b < 4; b++)
    begin
      if (sfr_wr && sfr_addr == bank_addr(b))
      begin
        next_st.bank[b] = sfr_wdata & bank_mask(b);
      end
    end

    // output enable of the port-byte pins only; single-pin bytes are not gated
    if (xram_wr && xram_addr == DIO_XRAM_PORT_EN)
    begin
      next_st.port_en = xram_wdata[DIO_PORT_EN_BIT];
    end

    // single-pin bytes
    for (int i = 0; i < DIO_NUM_SINGLE; i++)
    begin
      if (xram_wr && xram_addr == single_addr(i))
      begin
        next_st.single[i] = {xram_wdata[DIO_SINGLE_DIR_BIT], xram_wdata[DIO_SINGLE_DATA_BIT]};
      end
    end

    // resource select fields, two pins to a byte; the last byte has no routed pins
    for (int k = 0; k < DIO_NUM_RSEL_BYTES; k++)
    begin
      if (xram_wr && xram_addr == DIO_XRAM_RSEL_BASE + 16'(k) && 2 * k + 1 < DIO_NUM_ROUTED - 1)
      begin
        next_st.rsel[2*k] = xram_wdata[DIO_RSEL_LO_LSB +: 3];
        next_st.rsel[2*k+1] = xram_wdata[DIO_RSEL_HI_LSB +: 3];
      end
    end
    if (xram_wr && xram_addr == DIO_XRAM_BUTTON_RSEL)
    begin
      next_st.rsel[10] = xram_wdata[DIO_RSEL_LO_LSB +: 3];
    end

    // pad drive from the values that take effect this edge
    for (int p = 0; p < DIO_NUM_BANK_PINS; p++)
    begin
      next_st.pad_out[p] = next_st.bank[p/4][DIO_BANK_DATA_LSB + p%4];
      next_st.pad_oe[p] = next_st.bank[p/4][DIO_BANK_DIR_LSB + p%4] & next_st.port_en;
    end
    for (int i = 0; i < DIO_NUM_SINGLE; i++)
    begin
      next_st.pad_out[DIO_NUM_BANK_PINS + i] = next_st.single[i][DIO_SINGLE_DATA_BIT];
      next_st.pad_oe[DIO_NUM_BANK_PINS + i] = next_st.single[i][DIO_SINGLE_DIR_BIT];
    end

    // sfr read: data bits show pad levels, direction bits the latch
    next_st.sfr_rdata = 8'h00;
    for (int b = 0; b < 4; b++)
    begin
      if (sfr_addr == bank_addr(b))
      begin
        next_st.sfr_rdata = st.bank[b] & bank_mask(b);
        for (int j = 0; j < 4; j++)
        begin
          if (b * 4 + j < DIO_NUM_BANK_PINS)
            next_st.sfr_rdata[DIO_BANK_DATA_LSB + j] = st.pin_sync[b*4+j];
        end
      end
    end

    // i/o ram read, unmapped addresses read zero
    next_st.xram_rdata = 8'h00;
    if (xram_addr == DIO_XRAM_PORT_EN)
    begin
      next_st.xram_rdata[DIO_PORT_EN_BIT] = st.port_en;
    end
    else if (xram_addr == DIO_XRAM_BUTTON_RSEL)
    begin
      next_st.xram_rdata[DIO_RSEL_LO_LSB +: 3] = st.rsel[10];
    end
    else
    begin
      for (int i = 0; i < DIO_NUM_SINGLE; i++)
      begin
        if (xram_addr == single_addr(i))
        begin
          next_st.xram_rdata[DIO_SINGLE_DIR_BIT] = st.single[i][DIO_SINGLE_DIR_BIT];
          next_st.xram_rdata[DIO_SINGLE_DATA_BIT] = st.pin_sync[DIO_NUM_BANK_PINS + i];
        end
      end
      for (int k = 0; k < DIO_NUM_RSEL_BYTES; k++)
      begin
        if (xram_addr == DIO_XRAM_RSEL_BASE + 16'(k) && 2 * k + 1 < DIO_NUM_ROUTED - 1)
        begin
          next_st.xram_rdata[DIO_RSEL_LO_LSB +: 3] = st.rsel[2*k];
          next_st.xram_rdata[DIO_RSEL_HI_LSB +: 3] = st.rsel[2*k+1];
        end
      end
    end

    // routed resources and the internal pulse interrupt
    next_st.res = rt.res;
    next_st.pulse_irq = |ce_pulse;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.bank <= {4{DIO_BANK_DIR_RESET, DIO_BANK_DATA_RESET}} & {DIO_BANK_D_MASK, 24'hffffff};
      st.port_en <= DIO_PORT_EN_RESET;
      st.single <= {DIO_NUM_SINGLE{DIO_SINGLE_RESET}};
      st.rsel <= {DIO_NUM_ROUTED{DIO_RSEL_RESET}};
      st.pad_oe <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs, all straight from flops
  assign sfr_rdata = st.sfr_rdata;
  assign xram_rdata = st.xram_rdata;
  assign pin_out = st.pad_out;
  assign pin_oe = st.pad_oe;
  assign pulse_irq = st.pulse_irq;
  assign counter0_clock_input = st.res[0];
  assign counter1_clock_input = st.res[1];
  assign high_priority_ext_irq = st.res[2];
  assign low_priority_ext_irq = st.res[3];

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // helper: every select field holds a code that routes nothing
  logic all_sel_idle;
  always_comb
  begin
    all_sel_idle = 1'b1;
    for (int i = 0; i < DIO_NUM_ROUTED; i++)
    begin
      if (st.rsel[i] inside {DIO_RES_CNT0, DIO_RES_CNT1, DIO_RES_IRQ_HI, DIO_RES_IRQ_LO})
        all_sel_idle = 1'b0;
    end
  end

  sequence s_bank_d_write;
    sfr_wr && sfr_addr == DIO_SFR_BANK_D;
  endsequence

  sequence s_enable_write(logic v);
    xram_wr && xram_addr == DIO_XRAM_PORT_EN && xram_wdata[DIO_PORT_EN_BIT] == v;
  endsequence

  a_reset_all_inputs: assert property ($fell(reset) |-> pin_oe == '0)
    else $error("pads driven right after reset");

  a_reset_dir_out: assert property ($fell(reset) |-> st.bank[0][7:4] == 4'hf
      && st.bank[3][6:4] == 3'h7 && !st.port_en)
    else $error("port direction or enable wrong after reset");

  a_enable_gates: assert property (!st.port_en |-> pin_oe[14:0] == 15'h0)
    else $error("bank pin driven while enable is low");

  a_enable_write: assert property (s_enable_write(1'b1) ##1 (st.bank[3][4])
      |-> pin_oe[12] && pin_out[12] == st.bank[3][0])
    else $error("enabled output pin not driven");

  a_bank_write: assert property (s_bank_d_write |=> st.bank[3] == ($past(sfr_wdata) & DIO_BANK_D_MASK))
    else $error("port byte write not stored");

  a_pin_independent: assert property (st.port_en |-> pin_oe[14:0] ==
      {st.bank[3][6:4], st.bank[2][7:4], st.bank[1][7:4], st.bank[0][7:4]})
    else $error("bank pin direction does not follow its own bit");

  a_single_drive: assert property (st.single[0][1] |-> pin_oe[15] && pin_out[15] == st.single[0][0])
    else $error("pin 19 not driving its data bit");

  a_pin55_drive: assert property (pin_oe[24] == st.single[9][1])
    else $error("pin 55 drive does not follow its direction bit");

  a_pulse_route: assert property ((|ce_pulse) |=> pulse_irq ##1 pulse_irq == $past(|ce_pulse))
    else $error("engine pulse not passed to pulse interrupt");

  a_route_hi_irq: assert property (st.rsel[0] == DIO_RES_IRQ_HI && st.pin_sync[2]
      |=> high_priority_ext_irq)
    else $error("routed pin level lost");

  a_button_cnt0: assert property (st.rsel[10] == DIO_RES_CNT0 && st.btn_sync |=> counter0_clock_input)
    else $error("push button not routed to counter 0");

  a_idle_none: assert property (all_sel_idle |=> !counter0_clock_input && !counter1_clock_input
      && !high_priority_ext_irq && !low_priority_ext_irq)
    else $error("resource driven with no valid selection");

  a_or_combine: assert property (st.rsel[1] == DIO_RES_CNT1 && st.rsel[2] == DIO_RES_CNT1
      && (st.pin_sync[3] || st.pin_sync[4]) |=> counter1_clock_input)
    else $error("shared resource is not the or of its pins");

  ////////////////////////////////////////////////////////////////////////////
  // checks on stored fields and on the remaining routes

  // enabled output pin shows its data bit
  a_bank_data_out: assert property (st.port_en && st.bank[0][4] |-> pin_out[0] == st.bank[0][0])
    else $error("bank pin not driving its data bit");

  // pin 55 direction and data bits are stored
  a_single_write: assert property (xram_wr && xram_addr == DIO_XRAM_PIN55
      |=> st.single[9] == {$past(xram_wdata[1]), $past(xram_wdata[0])})
    else $error("pin 55 byte not stored");

  // pin 55 data bit reaches the pad value
  a_pin55_data: assert property (pin_out[24] == st.single[9][0])
    else $error("pin 55 data does not follow its data bit");

  // first select byte holds pins 2 and 3
  a_rsel_write: assert property (xram_wr && xram_addr == DIO_XRAM_RSEL_BASE
      |=> st.rsel[0] == $past(xram_wdata[2:0]) && st.rsel[1] == $past(xram_wdata[6:4]))
    else $error("select byte not stored");

  // push-button select field is stored
  a_button_rsel: assert property (xram_wr && xram_addr == DIO_XRAM_BUTTON_RSEL
      |=> st.rsel[10] == $past(xram_wdata[2:0]))
    else $error("button select not stored");

  // the byte with no routed pins leaves the button field alone
  a_rsel_unmapped: assert property (xram_wr && xram_addr == DIO_XRAM_RSEL_BASE + 16'h5
      |=> $stable(st.rsel[10]))
    else $error("unused select byte changed the button field");

  // counter 1 route from pin 6
  a_route_cnt1: assert property (st.rsel[4] == DIO_RES_CNT1 && st.pin_sync[6]
      |=> counter1_clock_input)
    else $error("pin not routed to counter 1");

  // low priority interrupt route from the push button
  a_route_lo_irq: assert property (st.rsel[10] == DIO_RES_IRQ_LO && st.btn_sync
      |=> low_priority_ext_irq)
    else $error("push button not routed to low interrupt");

  // clearing the enable takes effect on the next edge
  a_enable_clear: assert property (s_enable_write(1'b0) |=> !st.port_en)
    else $error("global enable not cleared");

  // no engine pulse, no pulse interrupt
  a_pulse_quiet: assert property (ce_pulse == 4'h0 |=> !pulse_irq)
    else $error("pulse interrupt without engine pulse");

  // unused bits of the last port byte stay zero
  a_bank_d_clean: assert property (!st.bank[3][7] && !st.bank[3][3])
    else $error("unused port bits set");

endmodule : dio_port_block
`default_nettype wire

// ===== inc/dio_pkg.sv
// constants, field layouts and types of the digital i/o port block
package dio_pkg;

  localparam int DIO_NUM_PINS = 25;
  localparam int DIO_NUM_BANK_PINS = 15;
  localparam int DIO_NUM_SINGLE = 10;
  localparam int DIO_NUM_ROUTED = 11;
  localparam int DIO_NUM_RES = 4;
  localparam int DIO_NUM_CE_PULSE = 4;

  // special-function register addresses of the four port bytes
  localparam logic [7:0] DIO_SFR_BANK_A = 8'h80;
  localparam logic [7:0] DIO_SFR_BANK_B = 8'h90;
  localparam logic [7:0] DIO_SFR_BANK_C = 8'ha0;
  localparam logic [7:0] DIO_SFR_BANK_D = 8'hb0;

  // i/o ram addresses
  localparam logic [15:0] DIO_XRAM_PORT_EN = 16'h270c;
  localparam logic [15:0] DIO_XRAM_RSEL_BASE = 16'h2009;
  localparam logic [15:0] DIO_XRAM_BUTTON_RSEL = 16'h2450;
  localparam logic [15:0] DIO_XRAM_SINGLE_BASE = 16'h2420;
  localparam logic [15:0] DIO_XRAM_PIN55 = 16'h2447;
  localparam int DIO_NUM_RSEL_BYTES = 6;

  // field positions
  localparam int DIO_PORT_EN_BIT = 5;
  localparam int DIO_BANK_DATA_LSB = 0;
  localparam int DIO_BANK_DIR_LSB = 4;
  localparam int DIO_SINGLE_DATA_BIT = 0;
  localparam int DIO_SINGLE_DIR_BIT = 1;
  localparam int DIO_RSEL_LO_LSB = 0;
  localparam int DIO_RSEL_HI_LSB = 4;
  localparam logic [7:0] DIO_BANK_D_MASK = 8'h77;

  // reset values
  localparam logic [3:0] DIO_BANK_DIR_RESET = 4'hf;
  localparam logic [3:0] DIO_BANK_DATA_RESET = 4'h0;
  localparam logic DIO_PORT_EN_RESET = 1'b0;
  localparam logic [1:0] DIO_SINGLE_RESET = 2'h0;
  localparam logic [2:0] DIO_RSEL_RESET = 3'h0;

  // resource select codes
  typedef enum logic [2:0] {
    DIO_RES_NONE = 3'h0,
    DIO_RES_RSVD = 3'h1,
    DIO_RES_CNT0 = 3'h2,
    DIO_RES_CNT1 = 3'h3,
    DIO_RES_IRQ_HI = 3'h4,
    DIO_RES_IRQ_LO = 3'h5
  } dio_res_t;

  // whole state of the port block
  typedef struct packed {
    logic [3:0][7:0] bank;
    logic port_en;
    logic [9:0][1:0] single;
    logic [10:0][2:0] rsel;
    logic [24:0] meta;
    logic [24:0] pin_sync;
    logic btn_meta;
    logic btn_sync;
    logic [7:0] sfr_rdata;
    logic [7:0] xram_rdata;
    logic [3:0] res;
    logic pulse_irq;
    logic [24:0] pad_out;
    logic [24:0] pad_oe;
  } dio_state_t;

endpackage : dio_pkg

// ===== inc/dio_route_if.sv
// carrier between the port block and its resource router
`timescale 1ns/10ps
`default_nettype none
interface dio_route_if;
  logic [10:0] level;
  logic [10:0][2:0] sel;
  logic [3:0] res;
  modport owner (output level, output sel, input res);
  modport router (input level, input sel, output res);
endinterface : dio_route_if
`default_nettype wire

// ===== hw/dio_resource_router.sv
// or-combining router of pin levels onto internal resources
`timescale 1ns/10ps
`default_nettype none
module dio_resource_router
  import dio_pkg::*;
(
  dio_route_if.router rt
);

  // true when a select field names the given resource
  function automatic logic sel_hit(input logic [2:0] sel, input dio_res_t code);
    sel_hit = (sel == code);
  endfunction : sel_hit

  // each resource is the or of every pin that selects it
  always_comb
  begin
    rt.res = 4'h0;
    for (int i = 0; i < DIO_NUM_ROUTED; i++)
    begin
      if (sel_hit(rt.sel[i], DIO_RES_CNT0)) rt.res[0] = rt.res[0] | rt.level[i];
      if (sel_hit(rt.sel[i], DIO_RES_CNT1)) rt.res[1] = rt.res[1] | rt.level[i];
      if (sel_hit(rt.sel[i], DIO_RES_IRQ_HI)) rt.res[2] = rt.res[2] | rt.level[i];
      if (sel_hit(rt.sel[i], DIO_RES_IRQ_LO)) rt.res[3] = rt.res[3] | rt.level[i];
    end
    // codes 1, 6 and 7 fall through all tests and route nothing
  end

endmodule : dio_resource_router
`default_nettype wire

// ===== tb/dio_board_model.sv
// board side of the pads: loads that follow driven pins, bench-set levels elsewhere
`timescale 1ns/10ps
`default_nettype none
module dio_board_model
  import dio_pkg::*;
(
  input wire logic [24:0] pin_out,
  input wire logic [24:0] pin_oe,
  input wire logic [24:0] ext_level,
  output logic [24:0] pin_in
);
  // a driven pad shows the block's value, an undriven one the board level
  always_comb
  begin
    for (int i = 0; i < DIO_NUM_PINS; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule : dio_board_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the digital i/o port block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dio_pkg::*;
;
  logic clk, reset, sfr_wr, xram_wr, push_button_input, pulse_irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xram_wdata, xram_rdata, q;
  logic [15:0] xram_addr;
  logic [24:0] pin_in, pin_out, pin_oe, ext;
  logic [3:0] ce_pulse;
  logic cnt0, cnt1, irq_hi, irq_lo;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // design and board
  dio_port_block DUT (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xram_addr(xram_addr),
    .xram_wr(xram_wr), .xram_wdata(xram_wdata), .xram_rdata(xram_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .push_button_input(push_button_input), .ce_pulse(ce_pulse), .pulse_irq(pulse_irq),
    .counter0_clock_input(cnt0), .counter1_clock_input(cnt1),
    .high_priority_ext_irq(irq_hi), .low_priority_ext_irq(irq_lo));
  dio_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one write strobe on the sfr (sel_x 0) or i/o ram (sel_x 1) side
  task automatic wr(input logic sel_x, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a[7:0];
    xram_addr = a;
    sfr_wdata = d;
    xram_wdata = d;
    sfr_wr = ~sel_x;
    xram_wr = sel_x;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    xram_wr = 1'b0;
  endtask : wr

  // read data is registered one edge after the address
  task automatic rd(input logic sel_x, input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a[7:0];
    xram_addr = a;
    @(posedge clk);
    #1;
    d = sel_x ? xram_rdata : sfr_rdata;
  endtask : rd

  // pad sync plus routing register take three edges
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    {sfr_wr, xram_wr, push_button_input} = 3'h0;
    {sfr_addr, sfr_wdata, xram_wdata} = 24'h0;
    xram_addr = 16'h0;
    ext = 25'h0;
    ce_pulse = 4'h0;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    check(pin_oe, 25'h0);
    rd(0, DIO_SFR_BANK_A, q);
    check(q, 8'hf0);
    rd(0, DIO_SFR_BANK_D, q);
    check(q, 8'h70);
    rd(1, DIO_XRAM_PIN55, q);
    check(q, 8'h00);
    // drive pin 12 high while the global enable is still off
    wr(0, DIO_SFR_BANK_D, 8'h11);
    check({pin_out[12], pin_oe[12]}, 2'b10);
    settle();
    rd(0, DIO_SFR_BANK_D, q);
    check(q, 8'h10);
    wr(1, DIO_XRAM_PORT_EN, 8'h20);
    check(pin_oe[14:0], 15'h1fff);
    settle();
    rd(0, DIO_SFR_BANK_D, q);
    check(q, 8'h11);
    rd(1, DIO_XRAM_PORT_EN, q);
    check(q, 8'h20);
    wr(0, DIO_SFR_BANK_A, 8'h50);
    check(pin_oe[3:0], 4'h5);
    wr(0, DIO_SFR_BANK_A, 8'h00);
    // single-pin bytes, pin 55 held against a high board level
    ext[24] = 1'b1;
    wr(1, DIO_XRAM_SINGLE_BASE + 16'h3, 8'h03);
    wr(1, DIO_XRAM_PIN55, 8'h02);
    check({pin_oe[24:15], pin_out[24:15]}, {10'h201, 10'h001});
    settle();
    rd(1, DIO_XRAM_SINGLE_BASE + 16'h3, q);
    check(q, 8'h03);
    rd(1, DIO_XRAM_PIN55, q);
    check(q, 8'h02);
    rd(1, DIO_XRAM_SINGLE_BASE, q);
    check(q, 8'h00);
    // every select code on pin 2 held high
    ext[2] = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr(1, DIO_XRAM_RSEL_BASE, {5'h0, c[2:0]});
      settle();
      check({cnt0, cnt1, irq_hi, irq_lo}, {c == 2, c == 3, c == 4, c == 5});
    end
    // pins 2 and 3 share the high interrupt
    wr(1, DIO_XRAM_RSEL_BASE, 8'h44);
    for (int m = 0; m < 4; m++)
    begin
      ext[3:2] = m[1:0];
      settle();
      check(irq_hi, |m[1:0]);
    end
    wr(1, DIO_XRAM_BUTTON_RSEL, 8'h05);
    push_button_input = 1'b1;
    settle();
    check(irq_lo, 1'b1);
    push_button_input = 1'b0;
    settle();
    check(irq_lo, 1'b0);
    // pin 2 as a high output still feeds counter 0
    ext[3:2] = 2'b00;
    wr(1, DIO_XRAM_RSEL_BASE, 8'h02);
    wr(0, DIO_SFR_BANK_A, 8'h44);
    settle();
    check({pin_oe[2], cnt0}, 2'b11);
    ce_pulse = 4'h2;
    @(posedge clk);
    #1;
    check(pulse_irq, 1'b1);
    ce_pulse = 4'h0;
    @(posedge clk);
    #1;
    check(pulse_irq, 1'b0);
    // a second reset in mid-run releases every pad
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    check(pin_oe, 25'h0);
    rd(0, DIO_SFR_BANK_A, q);
    check(q, 8'hf0);
    rd(1, DIO_XRAM_PORT_EN, q);
    check(q, 8'h00);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
